// [src/brfs_pkg.sv]
// constants for the banked register file and its status register
package brfs_pkg;
	localparam int          ADDR_W          = 7;
	localparam int          FILE_W          = 5;
	localparam int          DATA_W          = 8;
	localparam int          NUM_SFR         = 7;
	localparam int          NUM_GPR         = 25;
	localparam int          NUM_BANKED      = 16;
	localparam logic [4:0]  OFS_IND         = 5'h00;
	localparam logic [4:0]  OFS_TMR         = 5'h01;
	localparam logic [4:0]  OFS_PC_LOW      = 5'h02;
	localparam logic [4:0]  OFS_STATUS      = 5'h03;
	localparam logic [4:0]  OFS_PTR         = 5'h04;
	localparam logic [4:0]  OFS_OSC         = 5'h05;
	localparam logic [4:0]  OFS_IO          = 5'h06;
	localparam logic [4:0]  OFS_GPR_LO      = 5'h07;
	localparam logic [4:0]  OFS_GPR_HI      = 5'h10;
	localparam int          BANK_LSB        = 5;
	localparam int          ST_C            = 0;
	localparam int          ST_NC           = 1;
	localparam int          ST_Z            = 2;
	localparam int          ST_SLEEP        = 3;
	localparam int          ST_EXPIRY       = 4;
	localparam int          ST_PAGE         = 5;
	localparam int          ST_UNUSED       = 6;
	localparam int          ST_WAKE         = 7;
	localparam logic [7:0]  STATUS_RST      = 8'h18;
	localparam logic [7:0]  PTR_RST         = 8'h80;
	localparam logic [7:0]  OSC_RST         = 8'h00;
	localparam logic [7:0]  CLEAR_KEEP_MASK = 8'h1B;
	localparam logic [7:0]  CLEAR_SET_MASK  = 8'h04;
	localparam logic [7:0]  UNUSED_MASK     = 8'hBF;
endpackage

// [src/brfs_status_if.sv]
// status write path between the register file and the status unit
`timescale 1ns/1ps
interface brfs_status_if;
	logic        wr_en;
	logic [7:0]  wr_data;
	logic        clear_op;
	logic [7:0]  value;
	modport file (output wr_en, output wr_data, output clear_op,
		input value);
	modport unit (input wr_en, input wr_data, input clear_op,
		output value);
endinterface

// [src/brfs_status_unit.sv]
// status register with per-bit write protection
`timescale 1ns/1ps
module brfs_status_unit
	import brfs_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	brfs_status_if.unit     st,
	input  wire logic       flags_upd_i,
	input  wire logic [2:0] flags_i,
	input  wire logic       expiry_load_i,
	input  wire logic       expiry_val_i,
	input  wire logic       sleep_load_i,
	input  wire logic       sleep_val_i,
	input  wire logic       wake_load_i,
	input  wire logic       wake_val_i
);
	logic [7:0] status;
	logic [7:0] next_status;

	always_comb begin
		next_status = status;
		if (st.clear_op) begin
			next_status = (status & CLEAR_KEEP_MASK) | CLEAR_SET_MASK;
		end else if (st.wr_en) begin
			next_status[ST_WAKE] = st.wr_data[ST_WAKE];
			next_status[ST_PAGE] = st.wr_data[ST_PAGE];
			next_status[2:0]     = st.wr_data[2:0];
		end
		if (flags_upd_i) begin
			next_status[2:0] = flags_i;
		end
		if (expiry_load_i) begin
			next_status[ST_EXPIRY] = expiry_val_i;
		end
		if (sleep_load_i) begin
			next_status[ST_SLEEP] = sleep_val_i;
		end
		if (wake_load_i) begin
			next_status[ST_WAKE] = wake_val_i;
		end
		next_status = next_status & UNUSED_MASK;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			status <= STATUS_RST;
		end else begin
			status <= next_status;
		end
	end

	assign st.value = status;
endmodule

// [src/brfs_regfile.sv]
// banked data register file of the small controller core
`timescale 1ns/1ps
module brfs_regfile
	import brfs_pkg::*;
#(
	parameter bit BANKED = 1'b1
)(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [4:0]  file_addr_i,
	input  wire logic        wr_en_i,
	input  wire logic [7:0]  wr_data_i,
	input  wire logic        clear_op_i,
	input  wire logic        flags_upd_i,
	input  wire logic [2:0]  flags_i,
	input  wire logic        expiry_load_i,
	input  wire logic        expiry_val_i,
	input  wire logic        sleep_load_i,
	input  wire logic        sleep_val_i,
	input  wire logic        wake_load_i,
	input  wire logic        wake_val_i,
	input  wire logic [7:0]  timer_count_reg_i,
	input  wire logic [7:0]  program_counter_low_i,
	input  wire logic [7:0]  io_port_reg_i,
	output logic [7:0]       rd_data_o,
	output logic [7:0]       alu_reset_status_o,
	output logic [7:0]       indirect_pointer_o,
	output logic [7:0]       oscillator_trim_o,
	output logic             timer_wr_o,
	output logic             pc_low_wr_o,
	output logic             io_wr_o,
	output logic [7:0]       periph_wr_data_o
);
	// ************************************************************
	// storage
	// ************************************************************
	logic [7:0] gpr [NUM_GPR];
	logic [7:0] banked [NUM_BANKED];
	logic [7:0] pointer;
	logic [7:0] osc_trim;

	brfs_status_if st ();

	// ************************************************************
	// address resolution
	// ************************************************************
	function automatic logic [6:0] resolve(input logic [4:0] fa,
		input logic [7:0] ptr);
		logic [6:0] a;
		a = (fa == OFS_IND) ? ptr[6:0] : {ptr[6:5], fa};
		if (!BANKED || !a[4]) begin
			a[6:5] = 2'b00;
		end
		return a;
	endfunction

	// true when the resolved address names the given special register
	function automatic logic hits(input logic [6:0] e,
		input logic [4:0] ofs);
		return e[4:0] == ofs;
	endfunction

	logic [6:0] eff;
	logic       is_sfr;
	logic       is_bank;
	logic       ind_loop;
	logic [4:0] gidx;

	always_comb begin
		eff      = resolve(file_addr_i, pointer);
		ind_loop = hits(eff, OFS_IND);
		is_sfr   = (eff[4:0] < OFS_GPR_LO);
		is_bank  = BANKED && eff[5] && eff[4];
		gidx     = eff[4:0] - OFS_GPR_LO;
	end

	// ************************************************************
	// status unit
	// ************************************************************
	assign st.wr_en    = wr_en_i && !clear_op_i && hits(eff, OFS_STATUS);
	assign st.wr_data  = wr_data_i;
	assign st.clear_op = clear_op_i && hits(eff, OFS_STATUS);

	brfs_status_unit u_status (
		.ref_clk_i     (ref_clk_i),
		.rst_n_i       (rst_n_i),
		.st            (st),
		.flags_upd_i   (flags_upd_i),
		.flags_i       (flags_i),
		.expiry_load_i (expiry_load_i),
		.expiry_val_i  (expiry_val_i),
		.sleep_load_i  (sleep_load_i),
		.sleep_val_i   (sleep_val_i),
		.wake_load_i   (wake_load_i),
		.wake_val_i    (wake_val_i)
	);

	// ************************************************************
	// writes
	// ************************************************************
	logic                  any_wr;
	logic [7:0]            wval;
	logic [NUM_GPR-1:0]    gpr_we;
	logic [NUM_BANKED-1:0] bank_we;

	// a pointer that names itself must not write anything
	always_comb begin
		any_wr = (wr_en_i || clear_op_i) && !ind_loop;
		wval   = clear_op_i ? 8'h00 : wr_data_i;
	end

	// ************************************************************
	// special registers held here
	// ************************************************************
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pointer <= PTR_RST;
		end else if (any_wr && hits(eff, OFS_PTR)) begin
			pointer <= wval;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			osc_trim <= OSC_RST;
		end else if (any_wr && hits(eff, OFS_OSC)) begin
			osc_trim <= wval;
		end
	end

	// ************************************************************
	// general and banked registers
	// ************************************************************
	for (genvar g = 0; g < NUM_GPR; g++) begin : g_gpr
		assign gpr_we[g] = any_wr && !is_sfr && !is_bank &&
			gidx == 5'(g);
		always_ff @(posedge ref_clk_i) begin
			if (gpr_we[g]) begin
				gpr[g] <= wval;
			end
		end
	end

	// enables stay low when the variant has no banks
	for (genvar b = 0; b < NUM_BANKED; b++) begin : g_bank
		assign bank_we[b] = any_wr && is_bank && eff[3:0] == 4'(b);
		always_ff @(posedge ref_clk_i) begin
			if (bank_we[b]) begin
				banked[b] <= wval;
			end
		end
	end

	// owners outside store these; a clear hands over zero
	assign timer_wr_o       = any_wr && hits(eff, OFS_TMR);
	assign pc_low_wr_o      = any_wr && hits(eff, OFS_PC_LOW);
	assign io_wr_o          = any_wr && hits(eff, OFS_IO);
	assign periph_wr_data_o = wval;

	// ************************************************************
	// reads
	// ************************************************************
	always_comb begin
		if (ind_loop) begin
			rd_data_o = 8'h00;
		end else if (eff[4:0] == OFS_TMR) begin
			rd_data_o = timer_count_reg_i;
		end else if (eff[4:0] == OFS_PC_LOW) begin
			rd_data_o = program_counter_low_i;
		end else if (eff[4:0] == OFS_STATUS) begin
			rd_data_o = st.value;
		end else if (eff[4:0] == OFS_PTR) begin
			rd_data_o = pointer;
		end else if (eff[4:0] == OFS_OSC) begin
			rd_data_o = osc_trim;
		end else if (eff[4:0] == OFS_IO) begin
			rd_data_o = io_port_reg_i;
		end else if (is_bank) begin
			rd_data_o = banked[eff[3:0]];
		end else begin
			rd_data_o = gpr[gidx];
		end
	end

	// ************************************************************
	// register outputs
	// ************************************************************
	assign alu_reset_status_o = st.value;
	assign indirect_pointer_o = pointer;
	assign oscillator_trim_o  = osc_trim;
endmodule

// [bench/brfs_props.sv]
// checker on the register file ports
`timescale 1ns/1ps
module brfs_props
	import brfs_pkg::*;
(
	input wire logic       ref_clk_i,
	input wire logic       rst_n_i,
	input wire logic [4:0] file_addr_i,
	input wire logic       wr_en_i,
	input wire logic [7:0] wr_data_i,
	input wire logic       clear_op_i,
	input wire logic       flags_upd_i,
	input wire logic [2:0] flags_i,
	input wire logic       expiry_load_i,
	input wire logic       sleep_load_i,
	input wire logic       wake_load_i,
	input wire logic [7:0] rd_data_o,
	input wire logic [7:0] alu_reset_status_o,
	input wire logic [7:0] indirect_pointer_o,
	input wire logic       timer_wr_o,
	input wire logic [7:0] periph_wr_data_o
);
	wire logic [7:0] st = alu_reset_status_o;
	wire logic [7:0] pt = indirect_pointer_o;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_st;
		file_addr_i == OFS_STATUS && !flags_upd_i && !wake_load_i;
	endsequence
	chk_clear_pat: assert property ((s_st ##0 clear_op_i) |=>
		st[7:5] == 3'h0 && st[ST_Z]) else $error("clear pattern");
	chk_write_st: assert property ((s_st ##0 wr_en_i && !clear_op_i)
		|=> st[2:0] == $past(wr_data_i[2:0])) else $error("st write");
	chk_flags_win: assert property (flags_upd_i && wr_en_i &&
		file_addr_i == OFS_STATUS |=> st[2:0] == $past(flags_i))
		else $error("flags");
	chk_expiry_kept: assert property (!expiry_load_i |=>
		$stable(st[ST_EXPIRY])) else $error("expiry flag changed");
	chk_sleep_kept: assert property (!sleep_load_i |=>
		$stable(st[ST_SLEEP])) else $error("sleep flag changed");
	chk_bit6_zero: assert property (st[ST_UNUSED] == 1'b0)
		else $error("bit6");
	chk_ptr_write: assert property (wr_en_i && !clear_op_i &&
		file_addr_i == OFS_PTR |=> pt == $past(wr_data_i)) else $error("ptr");
	chk_ind_read: assert property (file_addr_i == OFS_IND &&
		pt[4:0] == 5'h03 |-> rd_data_o == st) else $error("indirect");
	chk_tmr_pulse: assert property (wr_en_i && !clear_op_i &&
		file_addr_i == OFS_TMR |-> timer_wr_o && periph_wr_data_o ==
		wr_data_i) else $error("timer pulse");
endmodule
bind brfs_regfile brfs_props u_props(.ref_clk_i, .rst_n_i, .file_addr_i,
	.wr_en_i, .wr_data_i, .clear_op_i, .flags_upd_i, .flags_i,
	.expiry_load_i, .sleep_load_i, .wake_load_i, .rd_data_o,
	.alu_reset_status_o,
	.indirect_pointer_o, .timer_wr_o, .periph_wr_data_o);

// [bench/brfs_periph_model.sv]
// peripheral owners storing values written through the file
`timescale 1ns/1ps
module brfs_periph_model (
	input  wire logic       ref_clk_i,
	input  wire logic       timer_wr_i,
	input  wire logic       pc_low_wr_i,
	input  wire logic       io_wr_i,
	input  wire logic [7:0] data_i,
	output logic [7:0]      timer_o,
	output logic [7:0]      pc_low_o,
	output logic [7:0]      io_o
);
	always_ff @(posedge ref_clk_i) begin
		if (timer_wr_i) timer_o <= data_i;
		if (pc_low_wr_i) pc_low_o <= data_i;
		if (io_wr_i) io_o <= data_i;
	end
endmodule

// [bench/brfs_regfile_test.sv]
// random and directed test of the banked register file
`timescale 1ns/1ps
module brfs_regfile_test;
	import brfs_pkg::*;
	logic       clk = 0, rst_n = 0, we = 0, clr = 0, fu = 0;
	logic       tl = 0, pl = 0, wl = 0, wv = 0, tw, pw, iw;
	logic       tv = 0, pv = 0;
	logic [4:0] fa = 0, a5;
	logic [2:0] fl = 0;
	logic [7:0] wd = 0, rd, st, ptr, osc, pwd, tm, pc, io, d, p = 8'h80;
	logic [7:0] mem [64];
	int         errors = 0, cmp_count = 0;
	initial forever #4 clk = ~clk;
	brfs_regfile dut(.ref_clk_i(clk), .rst_n_i(rst_n), .file_addr_i(fa),
		.wr_en_i(we), .wr_data_i(wd), .clear_op_i(clr), .flags_upd_i(fu),
		.flags_i(fl), .expiry_load_i(tl), .expiry_val_i(tv),
		.sleep_load_i(pl), .sleep_val_i(pv), .wake_load_i(wl),
		.wake_val_i(wv), .timer_count_reg_i(tm),
		.program_counter_low_i(pc),
		.io_port_reg_i(io), .rd_data_o(rd), .alu_reset_status_o(st),
		.indirect_pointer_o(ptr), .oscillator_trim_o(osc), .timer_wr_o(tw),
		.pc_low_wr_o(pw), .io_wr_o(iw), .periph_wr_data_o(pwd));
	brfs_periph_model peer(.ref_clk_i(clk), .timer_wr_i(tw),
		.pc_low_wr_i(pw), .io_wr_i(iw), .data_i(pwd), .timer_o(tm),
		.pc_low_o(pc), .io_o(io));
	task automatic check(string n, logic [7:0] s, logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("FAIL %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic op(logic [4:0] a, logic w, logic c, logic [7:0] v);
		@(negedge clk);
		fa = a;
		we = w;
		clr = c;
		wd = v;
	endtask
	// resolved file index, bank bit only above 0Fh
	function automatic logic [5:0] eff(logic [4:0] a, logic [7:0] q);
		logic [6:0] e;
		e = (a == 5'h00) ? q[6:0] : {q[6:5], a};
		return {e[5] & e[4], e[4:0]};
	endfunction
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#20000;
		errors++;
		results();
	end
	initial begin
		void'($urandom(6946));
		repeat (2) @(negedge clk);
		rst_n = 1;
		check("status", st, STATUS_RST);
		check("pointer", ptr, PTR_RST);
		op(OFS_STATUS, 1, 0, 8'hFF);
		op(OFS_STATUS, 0, 1, 8'h00);
		#1 check("st write", st, 8'hBF);
		op(OFS_STATUS, 1, 0, 8'h00);
		fu = 1;
		fl = 3'h2;
		#1 check("st clear", st, 8'h1F);
		op(OFS_STATUS, 0, 0, 8'h00);
		fu = 0;
		tl = 1;
		pl = 1;
		wl = 1;
		wv = 1;
		#1 check("st flags", st, 8'h1A);
		op(OFS_STATUS, 0, 0, 8'h00);
		{tl, pl, wl, tv, pv} = 5'h1B;
		#1 check("st loads", st, 8'h82);
		op(OFS_STATUS, 1, 0, 8'h00);
		{tl, pl} = 2'h0;
		#1 check("st reload", st, 8'h9A);
		op(OFS_PTR, 1, 0, 8'h25);
		op(OFS_IND, 1, 0, 8'h5A);
		op(OFS_IND, 0, 0, 8'h00);
		#1 check("alias", osc, 8'h5A);
		check("alias read", rd, 8'h5A);
		op(OFS_PTR, 1, 0, 8'h03);
		op(OFS_IND, 0, 0, 8'h00);
		#1 check("ind status", rd, 8'h18);
		op(OFS_PTR, 1, 0, 8'h00);
		op(OFS_IND, 1, 0, 8'hFF);
		#1 check("ind loop", rd, 8'h00);
		$display("status and alias done");
		foreach (mem[i]) mem[i] = 8'hXX;
		for (int i = 0; i < 3; i++) begin
			a5 = (i == 2) ? OFS_IO : 5'(i + 1);
			d = 8'($urandom);
			op(a5, 1, 0, d);
			op(a5, 0, 0, 8'h00);
			#1 check("periph", rd, d);
		end
		$display("peripheral writes done");
		repeat (60) begin
			a5 = 5'(OFS_GPR_LO + $urandom % 25);
			d = 8'($urandom);
			p = {1'b0, 2'($urandom), a5};
			op(OFS_PTR, 1, 0, p);
			op($urandom % 2 ? OFS_IND : a5, 1, $urandom % 8 == 0, d);
			mem[eff(a5, p)] = clr ? 8'h00 : d;
			a5 = 5'(OFS_GPR_LO + $urandom % 25);
			op(a5, 0, 0, 8'h00);
			#1 if (mem[eff(a5, p)] !== 8'hXX)
				check("gpr", rd, mem[eff(a5, p)]);
		end
		$display("random file done");
		results();
	end
endmodule
